// File: csic_pkg.sv
package csic_pkg;
    localparam int DATA_W = 8;
    localparam int SP_W = 11;
    localparam int PC_W = 13;
    localparam int IO_AW = 6;
    localparam int REG_AW = 5;
    localparam int IDX_W = 3;
    localparam int MAX_SRC = 8;
    localparam int SP_HIGH_BITS = 3;
    localparam int GIE_BIT = 7;
    localparam int VEC_SEL_BIT = 1;
    localparam int ENTRY_CYCLES = 4;

    // i/o space offsets
    localparam logic [5:0] IO_CORE_CTRL = 6'h35;
    localparam logic [5:0] IO_IRQ_EN = 6'h3a;
    localparam logic [5:0] IO_IRQ_FLAG = 6'h3b;
    localparam logic [5:0] IO_SP_LOW = 6'h3d;
    localparam logic [5:0] IO_SP_HIGH = 6'h3e;
    localparam logic [5:0] IO_STATUS = 6'h3f;

    localparam logic [10:0] SP_RESET = 11'h04ff;
    localparam logic [12:0] RESET_VEC_LOW = 13'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [3:0] {
        OP_NONE, OP_ALU, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_RETURN_FROM_INTERRUPT, OP_SEI, OP_CLI
    } csic_op_t;

    typedef enum logic [2:0] {
        ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_MOV
    } csic_alu_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_PUSH_LO = 2'b01,
        ST_PUSH_HI = 2'b11,
        ST_VECTOR = 2'b10
    } csic_state_t;

    typedef struct packed {
        logic wr;
        logic [IO_AW-1:0] addr;
        logic [DATA_W-1:0] data;
    } csic_io_t;

    typedef struct packed {
        logic dec1;
        logic inc1;
        logic dec2;
        logic inc2;
    } csic_sp_req_t;
endpackage

// File: csic_stack_ptr.sv
`timescale 1ns/1ns
module csic_stack_ptr
    import csic_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // register access and stack moves
    input wire csic_io_t i_io,
    input wire csic_sp_req_t i_req,
    // pointer state
    output logic [SP_W-1:0] o_sp,
    output logic [DATA_W-1:0] o_rd_high
);
    logic [SP_W-1:0] next_sp;
    logic wr_low;
    logic wr_high;

    assign wr_low = i_io.wr && (i_io.addr == IO_SP_LOW);
    assign wr_high = i_io.wr && (i_io.addr == IO_SP_HIGH);
    // upper bits not stored, so they read back zero
    assign o_rd_high = {{(DATA_W-SP_HIGH_BITS){1'b0}}, o_sp[SP_W-1:DATA_W]};

    always_comb begin
        next_sp = o_sp;
        if (i_req.dec1) begin
            next_sp = o_sp - SP_W'(1);
        end else if (i_req.inc1) begin
            next_sp = o_sp + SP_W'(1);
        end else if (i_req.dec2) begin
            next_sp = o_sp - SP_W'(2);
        end else if (i_req.inc2) begin
            next_sp = o_sp + SP_W'(2);
        end
    end

    // software write wins; a stack move requested by the core in the same cycle is dropped
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_sp <= SP_RESET;
        end else if (wr_low) begin
            o_sp[DATA_W-1:0] <= i_io.data;
        end else if (wr_high) begin
            o_sp[SP_W-1:DATA_W] <= i_io.data[SP_HIGH_BITS-1:0];
        end else begin
            o_sp <= next_sp;
        end
    end

    a_push_lowers: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_req.dec1 && !i_io.wr |=> o_sp == $past(o_sp) - SP_W'(1))
        else $error("push did not lower pointer by one");
    a_call_lowers: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_req.dec2 && !i_req.dec1 && !i_req.inc1 && !i_io.wr |=> o_sp == $past(o_sp) - SP_W'(2))
        else $error("call did not lower pointer by two");
    a_ret_raises: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_req == 4'b0001 && !i_io.wr |=> o_sp == $past(o_sp) + SP_W'(2))
        else $error("return did not raise pointer by two");
    a_high_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        wr_high |=> o_rd_high == DATA_W'($past(i_io.data[SP_HIGH_BITS-1:0])))
        else $error("unused high pointer bits not zero");
endmodule

// File: csic_irq_arb.sv
`timescale 1ns/1ns
module csic_irq_arb
    import csic_pkg::*;
#(
    parameter int NUM_SRC = 8,
    parameter logic [NUM_SRC-1:0] LEVEL_MASK = '0
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // sources
    input wire logic [NUM_SRC-1:0] i_event,
    input wire logic [NUM_SRC-1:0] i_level,
    input wire logic [NUM_SRC-1:0] i_enable,
    // flag clears
    input wire logic [NUM_SRC-1:0] i_clr_w1c,
    input wire logic i_ack,
    input wire logic [IDX_W-1:0] i_ack_idx,
    // result
    output logic [NUM_SRC-1:0] o_flags,
    output logic o_pending,
    output logic [IDX_W-1:0] o_idx
);
    logic [NUM_SRC-1:0] req;
    logic [NUM_SRC-1:0] ack_clr;

    function automatic logic [IDX_W-1:0] first_set(input logic [NUM_SRC-1:0] v);
        logic [IDX_W-1:0] r;
        r = '0;
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = IDX_W'(k);
            end
        end
        return r;
    endfunction

    generate
        for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
            assign ack_clr[g] = i_ack && (i_ack_idx == IDX_W'(g)) && !LEVEL_MASK[g];
            // level sources hold no memory of a vanished condition
            assign req[g] = i_enable[g] && (LEVEL_MASK[g] ? i_level[g] : o_flags[g]);
        end
    endgenerate

    // set beats both clears so an event in the clearing cycle is kept
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_flags <= '0;
        end else begin
            o_flags <= (o_flags & ~i_clr_w1c & ~ack_clr) | (i_event & ~LEVEL_MASK);
        end
    end

    assign o_pending = |req;
    assign o_idx = first_set(req);

    a_flag_set_wins: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_event & ~LEVEL_MASK) != '0
        |=> (o_flags & $past(i_event & ~LEVEL_MASK)) == $past(i_event & ~LEVEL_MASK))
        else $error("event flag lost");
    a_ack_clears: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (ack_clr & ~i_event) != '0 |=> (o_flags & $past(ack_clr & ~i_event)) == '0)
        else $error("flag not cleared on vectoring");
endmodule

// File: csic_core_ctrl.sv
`timescale 1ns/1ns
module csic_core_ctrl
    import csic_pkg::*;
#(
    parameter int NUM_SRC = 8,
    parameter logic [NUM_SRC-1:0] LEVEL_MASK = '0,
    parameter logic [PC_W-1:0] BOOT_START = 13'h1c00,
    parameter logic [PC_W-1:0] VEC_STRIDE = 13'h0002
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // instruction stream
    input wire csic_op_t i_op,
    input wire logic i_op_done,
    input wire logic [PC_W-1:0] i_pc,
    input wire logic [PC_W-1:0] i_ret_pc,
    // alu operands
    input wire csic_alu_t i_alu_fn,
    input wire logic [DATA_W-1:0] i_opnd_a,
    input wire logic [DATA_W-1:0] i_opnd_b,
    input wire logic [REG_AW-1:0] i_dst,
    // i/o register port
    input wire csic_io_t i_io,
    output logic [DATA_W-1:0] o_io_rdata,
    // interrupt sources
    input wire logic [NUM_SRC-1:0] i_irq_event,
    input wire logic [NUM_SRC-1:0] i_irq_level,
    // fuse and lock pins
    input wire logic i_boot_reset_vector_fuse,
    input wire logic i_application_lock_bit_two,
    input wire logic i_boot_lock_bit_two,
    // register write-back
    output logic o_wb_en,
    output logic [REG_AW-1:0] o_wb_dst,
    output logic [DATA_W-1:0] o_wb_data,
    // stack memory and program counter
    output logic o_stack_wr,
    output logic [SP_W-1:0] o_stack_addr,
    output logic [DATA_W-1:0] o_stack_data,
    output logic o_pc_load,
    output logic [PC_W-1:0] o_pc_target,
    output logic [PC_W-1:0] o_reset_vector,
    // core status
    output logic o_fetch_en,
    output logic o_irq_busy,
    output logic o_gie,
    output logic [SP_W-1:0] o_sp
);
    generate
        if (NUM_SRC < 1 || NUM_SRC > MAX_SRC) begin : g_bad_src
            $error("NUM_SRC out of range");
        end
    endgenerate

    csic_state_t state;
    logic [NUM_SRC-1:0] irq_en;
    logic vector_table_select;
    logic [PC_W-1:0] saved_pc;
    logic [IDX_W-1:0] taken_idx;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic gie;
    logic irq_take;
    logic blocked;
    logic in_boot;
    logic cli_now;
    logic [NUM_SRC-1:0] flags;
    logic [NUM_SRC-1:0] clr_w1c;
    logic pending;
    logic [IDX_W-1:0] win_idx;
    logic [SP_W-1:0] sp;
    logic [DATA_W-1:0] rd_high;
    csic_sp_req_t sp_req;
    logic [PC_W-1:0] vec_base;

    function automatic logic [DATA_W-1:0] alu(input csic_alu_t fn,
                                              input logic [DATA_W-1:0] a,
                                              input logic [DATA_W-1:0] b);
        unique case (fn)
            ALU_ADD: return a + b;
            ALU_SUB: return a - b;
            ALU_AND: return a & b;
            ALU_OR: return a | b;
            ALU_XOR: return a ^ b;
            ALU_MOV: return b;
            default: return a;
        endcase
    endfunction

    function automatic logic io_hit(input csic_io_t io, input logic [IO_AW-1:0] adr);
        return io.wr && (io.addr == adr);
    endfunction

    // fuse and lock pins are static but asynchronous to the core clock
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {i_boot_reset_vector_fuse, i_application_lock_bit_two, i_boot_lock_bit_two};
            sync_b <= sync_a;
        end
    end

    csic_stack_ptr u_sp (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_io(i_io),
        .i_req(sp_req),
        .o_sp(sp),
        .o_rd_high(rd_high)
    );

    assign clr_w1c = io_hit(i_io, IO_IRQ_FLAG) ? i_io.data[NUM_SRC-1:0] : '0;

    csic_irq_arb #(
        .NUM_SRC(NUM_SRC),
        .LEVEL_MASK(LEVEL_MASK)
    ) u_arb (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_event(i_irq_event),
        .i_level(i_irq_level),
        .i_enable(irq_en),
        .i_clr_w1c(clr_w1c),
        .i_ack(irq_take),
        .i_ack_idx(win_idx),
        .o_flags(flags),
        .o_pending(pending),
        .o_idx(win_idx)
    );

    // stack moves from retiring instructions, plus the entry push
    always_comb begin
        sp_req = '0;
        if (state == ST_RUN && i_op_done) begin
            sp_req.dec1 = (i_op == OP_PUSH);
            sp_req.inc1 = (i_op == OP_POP);
            sp_req.dec2 = (i_op == OP_CALL);
            sp_req.inc2 = (i_op == OP_RET) || (i_op == OP_RETURN_FROM_INTERRUPT);
        end else if (state == ST_PUSH_HI) begin
            sp_req.dec2 = 1'b1;
        end
    end

    assign in_boot = i_pc >= BOOT_START;
    assign blocked = (sync_b[1] && !in_boot) || (sync_b[0] && in_boot);
    assign cli_now = (i_op == OP_CLI) || (io_hit(i_io, IO_STATUS) && !i_io.data[GIE_BIT]);
    // registered enable already defers one instruction after set or return
    assign irq_take = (state == ST_RUN) && i_op_done && gie && pending && !blocked
        && !cli_now
        && (i_op != OP_RETURN_FROM_INTERRUPT) && (i_op != OP_SEI);
    assign vec_base = vector_table_select ? BOOT_START : RESET_VEC_LOW;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            gie <= 1'b0;
        end else if (irq_take) begin
            gie <= 1'b0;
        end else if (i_op_done && state == ST_RUN && i_op == OP_RETURN_FROM_INTERRUPT) begin
            gie <= 1'b1;
        end else if (i_op_done && state == ST_RUN && i_op == OP_SEI) begin
            gie <= 1'b1;
        end else if (i_op_done && state == ST_RUN && i_op == OP_CLI) begin
            gie <= 1'b0;
        end else if (io_hit(i_io, IO_STATUS)) begin
            gie <= i_io.data[GIE_BIT];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            irq_en <= '0;
            vector_table_select <= 1'b0;
        end else begin
            if (io_hit(i_io, IO_IRQ_EN)) begin
                irq_en <= i_io.data[NUM_SRC-1:0];
            end
            if (io_hit(i_io, IO_CORE_CTRL)) begin
                vector_table_select <= i_io.data[VEC_SEL_BIT];
            end
        end
    end

    // entry: only the return address goes on the stack, never status
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state <= ST_RUN;
            saved_pc <= '0;
            taken_idx <= '0;
            o_stack_wr <= 1'b0;
            o_stack_addr <= '0;
            o_stack_data <= '0;
            o_pc_load <= 1'b0;
            o_pc_target <= '0;
        end else begin
            o_stack_wr <= 1'b0;
            o_pc_load <= 1'b0;
            unique case (state)
                ST_RUN: begin
                    if (irq_take) begin
                        state <= ST_PUSH_LO;
                        saved_pc <= i_ret_pc;
                        taken_idx <= win_idx;
                        o_stack_wr <= 1'b1;
                        o_stack_addr <= sp - SP_W'({sp_req.dec2, sp_req.dec1})
                            + SP_W'({sp_req.inc2, sp_req.inc1});
                        o_stack_data <= i_ret_pc[DATA_W-1:0];
                    end
                end
                ST_PUSH_LO: begin
                    state <= ST_PUSH_HI;
                    o_stack_wr <= 1'b1;
                    o_stack_addr <= sp - SP_W'(1);
                    o_stack_data <= DATA_W'(saved_pc[PC_W-1:DATA_W]);
                end
                ST_PUSH_HI: begin
                    state <= ST_VECTOR;
                    o_pc_load <= 1'b1;
                    o_pc_target <= vec_base + (PC_W'(taken_idx) + PC_W'(1)) * VEC_STRIDE;
                end
                ST_VECTOR: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // alu result lands in the destination on the edge ending its cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_wb_en <= 1'b0;
            o_wb_dst <= '0;
            o_wb_data <= '0;
        end else begin
            o_wb_en <= i_op_done && (i_op == OP_ALU) && (state == ST_RUN);
            o_wb_dst <= i_dst;
            o_wb_data <= alu(i_alu_fn, i_opnd_a, i_opnd_b);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_io_rdata <= '0;
        end else begin
            unique case (i_io.addr)
                IO_SP_LOW: o_io_rdata <= sp[DATA_W-1:0];
                IO_SP_HIGH: o_io_rdata <= rd_high;
                IO_STATUS: o_io_rdata <= DATA_W'(gie) << GIE_BIT;
                IO_IRQ_EN: o_io_rdata <= DATA_W'(irq_en);
                IO_IRQ_FLAG: o_io_rdata <= DATA_W'(flags);
                IO_CORE_CTRL: o_io_rdata <= DATA_W'(vector_table_select) << VEC_SEL_BIT;
                default: o_io_rdata <= BYTE_ZERO;
            endcase
        end
    end

    // fetch keeps running beside execute except while vectoring
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_fetch_en <= 1'b0;
            o_irq_busy <= 1'b0;
            o_gie <= 1'b0;
            o_sp <= SP_RESET;
            o_reset_vector <= RESET_VEC_LOW;
        end else begin
            o_fetch_en <= !irq_take && (state == ST_RUN || state == ST_VECTOR);
            o_irq_busy <= irq_take || (state != ST_RUN && state != ST_VECTOR);
            o_gie <= gie;
            o_sp <= sp;
            o_reset_vector <= sync_b[2] ? BOOT_START : RESET_VEC_LOW;
        end
    end

    sequence s_entry;
        state == ST_PUSH_LO ##1 state == ST_PUSH_HI ##1 state == ST_VECTOR ##1 state == ST_RUN;
    endsequence

    sequence s_pushes;
        o_stack_wr ##1 o_stack_wr ##1 o_pc_load;
    endsequence

    a_entry_four: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        irq_take |=> s_entry)
        else $error("interrupt entry not four cycles");
    a_entry_push: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        irq_take |=> s_pushes)
        else $error("counter not pushed before vector");
    a_take_clears: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        irq_take |=> !gie [*3])
        else $error("global enable not cleared on entry");
    a_return_from_interrupt_sets: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        state == ST_RUN && i_op_done && i_op == OP_RETURN_FROM_INTERRUPT |=> gie && sp == $past(sp) + SP_W'(2))
        else $error("return did not restore enable");
    a_cli_blocks: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_op_done && i_op == OP_CLI |-> !irq_take ##1 !gie)
        else $error("interrupt taken across clear");
    a_sei_defers: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_op_done && (i_op == OP_SEI || i_op == OP_RETURN_FROM_INTERRUPT) |-> !irq_take)
        else $error("interrupt taken before next instruction");
    a_needs_enable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        irq_take |-> gie && (irq_en[win_idx]) && !blocked)
        else $error("interrupt taken while disabled");
    a_alu_single: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_op_done && i_op == OP_ALU && state == ST_RUN && i_alu_fn == ALU_ADD
        |=> o_wb_en && o_wb_data == DATA_W'($past(i_opnd_a) + $past(i_opnd_b)))
        else $error("alu result not written next edge");
    a_vector_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        state == ST_PUSH_HI && taken_idx == '0 && !vector_table_select
        |=> o_pc_load && o_pc_target == VEC_STRIDE)
        else $error("wrong vector for source zero");
endmodule

// File: csic_prog_model.sv
`timescale 1ns/1ns
module csic_prog_model
    import csic_pkg::*;
(
    // clock
    input wire logic i_clk_sys,
    // core stall
    input wire logic i_irq_busy,
    // retiring instruction
    output csic_op_t o_op,
    output logic o_op_done
);
    initial begin
        o_op = OP_NONE;
        o_op_done = 1'b0;
    end
    // no retire during entry: the core would drop it
    task automatic retire(input csic_op_t op, output bit timed_out);
        int n;
        n = 0;
        #1;
        while (i_irq_busy !== 1'b0 && n < 40) begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        timed_out = (n >= 40);
        @(posedge i_clk_sys);
        o_op <= op;
        o_op_done <= 1'b1;
        @(posedge i_clk_sys);
        o_op_done <= 1'b0;
    endtask
endmodule

// File: tb_cpu_stack_and_interrupt_control.sv
`timescale 1ns/1ns
module tb_cpu_stack_and_interrupt_control;
    import csic_pkg::*;
    logic i_clk_sys;
    logic i_rst_n;
    csic_op_t i_op;
    logic i_op_done;
    logic [PC_W-1:0] i_pc;
    logic [PC_W-1:0] i_ret_pc;
    csic_alu_t i_alu_fn;
    logic [DATA_W-1:0] i_opnd_a;
    logic [DATA_W-1:0] i_opnd_b;
    logic [REG_AW-1:0] i_dst;
    csic_io_t i_io;
    logic [DATA_W-1:0] rdata;
    logic [7:0] i_irq_event;
    logic [7:0] lvl;
    logic fuse;
    logic lock_app;
    logic lock_boot;
    logic fetch;
    logic wb_en;
    logic [REG_AW-1:0] wb_dst;
    logic [DATA_W-1:0] wb_data;
    logic st_wr;
    logic [SP_W-1:0] st_addr;
    logic [DATA_W-1:0] st_data;
    logic pc_load;
    logic [PC_W-1:0] pc_tgt;
    logic [PC_W-1:0] rst_vec;
    logic busy;
    logic gie;
    logic [SP_W-1:0] sp;
    int fails;
    int n_compared;
    bit to;
    logic [7:0] alu_exp [6] = '{8'h00, 8'h8a, 8'h01, 8'hff, 8'hfe, 8'h3b};

    csic_prog_model pm (.i_clk_sys(i_clk_sys), .i_irq_busy(busy), .o_op(i_op),
        .o_op_done(i_op_done));

    csic_core_ctrl #(.LEVEL_MASK(8'h80)) uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_op(i_op), .i_op_done(i_op_done), .i_pc(i_pc), .i_ret_pc(i_ret_pc),
        .i_alu_fn(i_alu_fn), .i_opnd_a(i_opnd_a), .i_opnd_b(i_opnd_b), .i_dst(i_dst),
        .i_io(i_io), .o_io_rdata(rdata), .i_irq_event(i_irq_event), .i_irq_level(lvl),
        .i_boot_reset_vector_fuse(fuse), .i_application_lock_bit_two(lock_app),
        .i_boot_lock_bit_two(lock_boot), .o_wb_en(wb_en), .o_wb_dst(wb_dst),
        .o_wb_data(wb_data), .o_stack_wr(st_wr), .o_stack_addr(st_addr),
        .o_stack_data(st_data), .o_pc_load(pc_load), .o_pc_target(pc_tgt),
        .o_reset_vector(rst_vec), .o_fetch_en(fetch), .o_irq_busy(busy), .o_gie(gie),
        .o_sp(sp));

    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task io_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_io <= {1'b1, a, d};
        @(posedge i_clk_sys);
        i_io <= {1'b0, a, d};
    endtask

    task io_rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_io <= {1'b0, a, 8'h00};
        @(posedge i_clk_sys);
        #1;
        chk(rdata, exp);
    endtask

    task op(input csic_op_t o);
        pm.retire(o, to);
        if (to) begin
            fails++;
            finish_test();
        end
    endtask

    task idle_chk(input logic [10:0] exp);
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk(sp, exp);
        chk(busy, 1'b0);
        chk(fetch, 1'b1);
    endtask

    task pulse(input logic [7:0] ev);
        @(posedge i_clk_sys);
        i_irq_event <= ev;
        @(posedge i_clk_sys);
        i_irq_event <= 8'h00;
    endtask

    // entry walk: low byte first at the top, high byte below, then vector
    task entry(input logic [10:0] sp0, input logic [12:0] tgt);
        #1;
        chk(st_wr, 1'b1);
        chk(fetch, 1'b0);
        chk(st_addr, sp0);
        chk(st_data, i_ret_pc[7:0]);
        @(posedge i_clk_sys);
        #1;
        chk(st_addr, sp0 - 11'h001);
        chk(st_data, {3'b000, i_ret_pc[12:8]});
        @(posedge i_clk_sys);
        #1;
        chk(pc_load, 1'b1);
        chk(pc_tgt, tgt);
    endtask

    initial begin
        i_rst_n = 1'b0;
        i_pc = 13'h0100;
        i_ret_pc = 13'h1abc;
        i_alu_fn = ALU_ADD;
        i_opnd_a = 8'h00;
        i_opnd_b = 8'h00;
        i_dst = 5'h00;
        i_io = '0;
        i_irq_event = 8'h00;
        lvl = 8'h00;
        fuse = 1'b0;
        lock_app = 1'b0;
        lock_boot = 1'b0;
        fails = 0;
        n_compared = 0;
        repeat (3) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        #1;
        chk(sp, SP_RESET);
        chk(rst_vec, RESET_VEC_LOW);
        io_rd(IO_SP_LOW, 8'hff);
        io_rd(IO_SP_HIGH, 8'h04);
        io_wr(IO_SP_HIGH, 8'hff);
        io_rd(IO_SP_HIGH, 8'h07);
        io_wr(IO_SP_LOW, 8'h10);
        io_wr(IO_SP_HIGH, 8'h02);
        idle_chk(11'h210);
        op(OP_PUSH);
        idle_chk(11'h20f);
        op(OP_POP);
        idle_chk(11'h210);
        op(OP_CALL);
        idle_chk(11'h20e);
        op(OP_RET);
        idle_chk(11'h210);
        for (int k = 0; k < 6; k++) begin
            @(posedge i_clk_sys);
            i_alu_fn <= csic_alu_t'(k);
            i_opnd_a <= 8'hc5;
            i_opnd_b <= 8'h3b;
            i_dst <= REG_AW'(k + 3);
            op(OP_ALU);
            #1;
            chk(wb_en, 1'b1);
            chk(wb_data, alu_exp[k]);
            chk(wb_dst, REG_AW'(k + 3));
        end
        // sources 1 and 2 pend while the global enable is off
        io_wr(IO_IRQ_EN, 8'h06);
        pulse(8'h06);
        op(OP_NONE);
        idle_chk(11'h210);
        io_rd(IO_IRQ_FLAG, 8'h06);
        op(OP_SEI);
        idle_chk(11'h210);
        op(OP_NONE);
        entry(11'h210, 13'h0004);
        io_rd(IO_STATUS, 8'h00);
        io_rd(IO_IRQ_FLAG, 8'h04);
        op(OP_RETURN_FROM_INTERRUPT);
        idle_chk(11'h210);
        chk(gie, 1'b1);
        op(OP_CLI);
        idle_chk(11'h210);
        io_rd(IO_STATUS, 8'h00);
        io_wr(IO_IRQ_FLAG, 8'h04);
        io_rd(IO_IRQ_FLAG, 8'h00);
        pulse(8'h04);
        io_wr(IO_CORE_CTRL, 8'h02);
        io_wr(IO_STATUS, 8'h80);
        op(OP_NONE);
        entry(11'h210, 13'h1c06);
        // application lock with the counter below the boot section
        @(posedge i_clk_sys);
        lock_app <= 1'b1;
        fuse <= 1'b1;
        io_wr(IO_IRQ_EN, 8'h07);
        io_wr(IO_CORE_CTRL, 8'h00);
        pulse(8'h03);
        io_wr(IO_STATUS, 8'h80);
        op(OP_NONE);
        idle_chk(11'h20e);
        chk(rst_vec, 13'h1c00);
        // boot lock only bites inside the boot section
        @(posedge i_clk_sys);
        lock_app <= 1'b0;
        lock_boot <= 1'b1;
        i_pc <= 13'h1c10;
        repeat (3) @(posedge i_clk_sys);
        op(OP_NONE);
        idle_chk(11'h20e);
        @(posedge i_clk_sys);
        i_pc <= 13'h0100;
        op(OP_NONE);
        entry(11'h20e, 13'h0002);
        // level source: no flag, and a vanished level takes nothing
        @(posedge i_clk_sys);
        lvl <= 8'h80;
        io_rd(IO_IRQ_FLAG, 8'h02);
        @(posedge i_clk_sys);
        lvl <= 8'h00;
        io_wr(IO_IRQ_EN, 8'h80);
        io_wr(IO_STATUS, 8'h80);
        op(OP_NONE);
        idle_chk(11'h20c);
        @(posedge i_clk_sys);
        lvl <= 8'h80;
        op(OP_NONE);
        entry(11'h20c, 13'h0010);
        finish_test();
    end
endmodule
